// >>> rtl/ddstw_dev.sv
// Device end: serial decode, tuning/offset words, select and reset
//
// The placing of the registers and the APB slave port were decided locally.
module ddstw_dev (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Link
    ddstw_if.dev             lnk,
    // Synthesizer outputs
    output logic [27:0]      phase_acc,
    output logic [11:0]      phase_out,
    output logic             out_valid,
    output logic [27:0]      active_tune,
    output logic [11:0]      active_offs
);
    localparam int TW = ddstw_pkg::TUNE_W;
    localparam int HW = ddstw_pkg::HALF_W;
    localparam int OW = ddstw_pkg::OFFS_W;

    // Oversampled serial link: sclk and data synchronised into pclk
    logic [2:0] lnk_s;
    ddstw_sync #(.W(3)) u_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .d     ({lnk.sclk, lnk.sync_n, lnk.serial_in}),
        .q     (lnk_s)
    );
    logic sclk_d_ff;
    logic [15:0] shreg_ff;
    logic [4:0]  cnt_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) sclk_d_ff <= 1'b0;
        else          sclk_d_ff <= lnk_s[2];
    end
    // Data taken on falling sclk while frame low
    wire fall     = sclk_d_ff & ~lnk_s[2];
    wire shift_en = fall & ~lnk_s[1];
    wire [15:0] nxt_shreg = {shreg_ff[14:0], lnk_s[0]};
    wire word_done = shift_en & (cnt_ff == 5'h0f);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shreg_ff <= 16'h0000;
            cnt_ff   <= 5'h00;
        end else begin
            if (lnk_s[1])      cnt_ff <= 5'h00;
            else if (shift_en) cnt_ff <= word_done ? 5'h00 : cnt_ff + 5'h01;
            if (shift_en)      shreg_ff <= nxt_shreg;
        end
    end

    // Decode
    logic [15:0]   ctrl_ff;
    logic [TW-1:0] tune_a_ff;
    logic [TW-1:0] tune_b_ff;
    logic [OW-1:0] offs_a_ff;
    logic [OW-1:0] offs_b_ff;
    logic          lsb_seen_ff;
    wire [1:0] addr = nxt_shreg[15:14];
    wire [HW-1:0] dat = nxt_shreg[HW-1:0];
    wire is_ctrl = word_done & (addr == ddstw_pkg::ADDR_CTRL);
    wire is_ta   = word_done & (addr == ddstw_pkg::ADDR_TUNEA);
    wire is_tb   = word_done & (addr == ddstw_pkg::ADDR_TUNEB);
    wire is_of   = word_done & (addr == ddstw_pkg::ADDR_OFFS);
    wire full_md = ctrl_ff[ddstw_pkg::BIT_FULL];
    // Full mode: first write low, second high; half mode by half pick
    wire hi_half = full_md ? lsb_seen_ff
                           : ctrl_ff[ddstw_pkg::BIT_HALF];
    function automatic logic [TW-1:0] upd(input logic [TW-1:0] o,
                                           input logic hi,
                                           input logic [HW-1:0] d);
        upd = hi ? {d, o[HW-1:0]} : {o[TW-1:HW], d};
    endfunction : upd
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff     <= ddstw_pkg::CTRL_RESET;
            tune_a_ff   <= '0;
            tune_b_ff   <= '0;
            offs_a_ff   <= '0;
            offs_b_ff   <= '0;
            lsb_seen_ff <= 1'b0;
        end else begin
            if (is_ctrl) begin
                ctrl_ff     <= nxt_shreg;
                lsb_seen_ff <= 1'b0;
            end
            if (is_ta) tune_a_ff <= upd(tune_a_ff, hi_half, dat);
            if (is_tb) tune_b_ff <= upd(tune_b_ff, hi_half, dat);
            if ((is_ta | is_tb) & full_md)
                lsb_seen_ff <= ~lsb_seen_ff;
            if (is_of & ~nxt_shreg[ddstw_pkg::BIT_OSEL])
                offs_a_ff <= nxt_shreg[OW-1:0];
            if (is_of & nxt_shreg[ddstw_pkg::BIT_OSEL])
                offs_b_ff <= nxt_shreg[OW-1:0];
        end
    end

    // Select pins sampled on the falling edge
    logic tpin_ff;
    logic opin_ff;
    always_ff @(negedge pclk or negedge presetn) begin
        if (!presetn) begin
            tpin_ff <= 1'b0;
            opin_ff <= 1'b0;
        end else begin
            tpin_ff <= lnk.tune_pick_pin;
            opin_ff <= lnk.offset_pick_pin;
        end
    end
    wire src   = ctrl_ff[ddstw_pkg::BIT_SRC];
    wire tpick = src ? tpin_ff : ctrl_ff[ddstw_pkg::BIT_TPICK];
    wire opick = src ? opin_ff : ctrl_ff[ddstw_pkg::BIT_OPICK];
    wire [TW-1:0] tsel = tpick ? tune_b_ff : tune_a_ff;
    wire [OW-1:0] osel = opick ? offs_b_ff : offs_a_ff;

    // Reset: pin asserts at once, release sampled on falling edge
    logic pin_rel_ff;
    always_ff @(negedge pclk or posedge lnk.reset_pin) begin
        if (lnk.reset_pin) pin_rel_ff <= 1'b1;
        else               pin_rel_ff <= 1'b0;
    end
    wire bit_rst = ctrl_ff[ddstw_pkg::BIT_RST];
    wire dds_rst = src ? (lnk.reset_pin | pin_rel_ff)
                       : bit_rst;

    logic [2:0] dly_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_acc   <= '0;
            phase_out   <= '0;
            out_valid   <= 1'b0;
            dly_ff      <= 3'h0;
            active_tune <= '0;
            active_offs <= '0;
        end else begin
            active_tune <= tsel;
            active_offs <= osel;
            if (dds_rst) begin
                phase_acc <= '0;
                phase_out <= '0;
                out_valid <= 1'b0;
                dly_ff    <= 3'h0;
            end else begin
                phase_acc <= phase_acc + tsel;
                phase_out <= phase_acc[TW-1:TW-OW] + osel;
                if (dly_ff != 3'(ddstw_pkg::OUT_DELAY - 1))
                    dly_ff <= dly_ff + 3'h1;
                else
                    out_valid <= 1'b1;
            end
        end
    end
endmodule : ddstw_dev

// >>> rtl/ddstw_pkg.sv
// Shared constants for the tuning word register bank and its host end
// How it works
// - Two 28-bit tuning words set frequency
// - Two 12-bit offsets added to phase
// - Source bit picks pins or control bits
// - Tune pick zero/one selects tuning word
// - Offset pick zero/one selects offset word
// - Host holds pins stable when bits select
// - Top bits 01/10 write tuning halves
// - Top bits 00 is control word
// - Full width: low half then high
// - Half mode: half pick chooses half
// - Host alternates tuning words for sweeps
// - Top bits 11 write offset word
// - Reset clears accumulator, keeps registers
// - Output returns seven cycles after release
// - Reset from bit or pin by source
// - Pin reset immediate, release sampled
// - Host resets at power-up then releases
// - Reset control bit is bit 8
package ddstw_pkg;
    localparam int WORD_W      = 16;
    localparam int TUNE_W      = 28;
    localparam int HALF_W      = 14;
    localparam int OFFS_W      = 12;
    localparam int BIT_FULL    = 13;
    localparam int BIT_HALF    = 12;
    localparam int BIT_SRC     = 9;
    localparam int BIT_TPICK   = 11;
    localparam int BIT_OPICK   = 10;
    localparam int BIT_RST     = 8;
    localparam int BIT_OSEL    = 13;
    localparam int OUT_DELAY   = 7;
    localparam logic [1:0] ADDR_CTRL  = 2'h0;
    localparam logic [1:0] ADDR_TUNEA = 2'h1;
    localparam logic [1:0] ADDR_TUNEB = 2'h2;
    localparam logic [1:0] ADDR_OFFS  = 2'h3;
    localparam logic [WORD_W-1:0] CTRL_RESET = 16'h0000;
    // Host APB map
    localparam logic [7:0] REG_TX     = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_PINS   = 8'h08;
    localparam int SCLK_DIV = 2;
endpackage : ddstw_pkg

// >>> rtl/ddstw_if.sv
// Link between host end and register bank
interface ddstw_if;
    logic sclk;
    logic sync_n;
    logic serial_in;
    logic tune_pick_pin;
    logic offset_pick_pin;
    logic reset_pin;
    modport host (output sclk, output sync_n, output serial_in,
                  output tune_pick_pin, output offset_pick_pin,
                  output reset_pin);
    modport dev  (input sclk, input sync_n, input serial_in,
                  input tune_pick_pin, input offset_pick_pin,
                  input reset_pin);
endinterface : ddstw_if

// >>> rtl/ddstw_sync.sv
// Two-flop level synchroniser
module ddstw_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Level
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            q       <= '0;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule : ddstw_sync

// >>> rtl/ddstw_host.sv
// Host end: APB-driven serial word writer and pin driver
module ddstw_host (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Link
    ddstw_if.host            lnk
);
    logic [15:0] sh_ff;
    logic [4:0]  bits_ff;
    logic        busy_ff;
    logic [1:0]  div_ff;
    logic        sclk_ff;
    logic        sync_ff;
    logic [2:0]  pins_ff;
    wire acc  = psel & penable;
    wire wr_tx   = acc & pwrite & (paddr == ddstw_pkg::REG_TX) & ~busy_ff;
    wire wr_pins = acc & pwrite & (paddr == ddstw_pkg::REG_PINS);
    wire hit = (paddr == ddstw_pkg::REG_TX) | (paddr == ddstw_pkg::REG_STATUS)
             | (paddr == ddstw_pkg::REG_PINS);
    wire [31:0] rd = (paddr == ddstw_pkg::REG_STATUS) ? {31'h0, busy_ff} :
                     (paddr == ddstw_pkg::REG_PINS)   ? {29'h0, pins_ff} :
                     32'h0;
    wire tick = (div_ff == 2'(ddstw_pkg::SCLK_DIV - 1));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            pins_ff <= 3'h4;              // Reset pin high from power-up
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit;
            prdata  <= rd;
            if (wr_pins) pins_ff <= pwdata[2:0];
        end
    end
    // Msb first, data set while sclk high, taken on fall
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_ff   <= 16'h0000;
            bits_ff <= 5'h00;
            busy_ff <= 1'b0;
            div_ff  <= 2'h0;
            sclk_ff <= 1'b1;
            sync_ff <= 1'b1;
        end else if (wr_tx) begin
            sh_ff   <= pwdata[15:0];
            bits_ff <= 5'h10;
            busy_ff <= 1'b1;
            sync_ff <= 1'b0;
            div_ff  <= 2'h0;
        end else if (busy_ff) begin
            div_ff <= tick ? 2'h0 : div_ff + 2'h1;
            if (tick) begin
                sclk_ff <= ~sclk_ff;
                if (!sclk_ff) begin
                    sh_ff   <= {sh_ff[14:0], 1'b0};
                    bits_ff <= bits_ff - 5'h01;
                    if (bits_ff == 5'h01) begin
                        busy_ff <= 1'b0;
                        sync_ff <= 1'b1;
                    end
                end
            end
        end
    end
    assign lnk.sclk            = sclk_ff;
    assign lnk.sync_n          = sync_ff;
    assign lnk.serial_in       = sh_ff[15];
    assign lnk.tune_pick_pin   = pins_ff[0];
    assign lnk.offset_pick_pin = pins_ff[1];
    assign lnk.reset_pin       = pins_ff[2];
endmodule : ddstw_host

// >>> dv/ddstw_assertions.sv
// Link framing and reset checks for the tuning word bank
module ddstw_assertions (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // Link
    input wire logic        sclk,
    input wire logic        sync_n,
    input wire logic        serial_in,
    // Device outputs
    input wire logic        out_valid,
    input wire logic [27:0] phase_acc,
    input wire logic [27:0] active_tune
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       sclk_ff;
    logic [4:0] fall_cnt_ff;
    logic [4:0] nxt_fall_cnt;
    // Count falling serial clocks inside one frame
    assign nxt_fall_cnt = sync_n ? 5'h00
                        : fall_cnt_ff + {4'h0, sclk_ff & ~sclk};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_ff     <= 1'b1;
            fall_cnt_ff <= 5'h00;
        end else begin
            sclk_ff     <= sclk;
            fall_cnt_ff <= nxt_fall_cnt;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_bits; $rose(sync_n) |-> fall_cnt_ff == 5'h10; endproperty
    property p_half; !sync_n && $changed(sclk) |=> $stable(sclk) || sync_n;
    endproperty
    property p_steady; !sync_n && $fell(sclk) |-> $stable(serial_in);
    endproperty
    property p_frame; $fell(sync_n) |-> ##[60:80] $rose(sync_n); endproperty
    property p_idle; sync_n [*4] |-> $stable(sclk); endproperty
    // Low at both depths so a short warm-up is caught
    property p_delay;
        $rose(out_valid) |-> !$past(out_valid, 6) && !$past(out_valid, 3);
    endproperty
    property p_keep; $fell(out_valid) |-> $stable(active_tune); endproperty
    property p_clear; $fell(out_valid) |-> ##2 phase_acc == 28'h0000000;
    endproperty
    a_bits: assert property (p_bits) else $error("frame bit count");
    a_half: assert property (p_half) else $error("clock half short");
    a_steady: assert property (p_steady) else $error("data moved");
    a_frame: assert property (p_frame) else $error("frame length");
    a_idle: assert property (p_idle) else $error("idle clock moved");
    a_delay: assert property (p_delay) else $error("early output");
    a_keep: assert property (p_keep) else $error("tune lost");
    a_clear: assert property (p_clear) else $error("acc kept");
    c_frame: cover property ($rose(sync_n));
    c_up: cover property ($rose(out_valid));
    c_down: cover property ($fell(out_valid));
endmodule : ddstw_assertions

// >>> dv/tb_dds_tuning_word_registers.sv
// Bench: host end writes serial words, device end is checked
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin \
    miscompares++; \
    $display("Error at %0t: got %h exp %h", $time, (a), (b)); \
end end
module tb_dds_tuning_word_registers;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic        pready, pslverr, perr, out_valid;
    logic [27:0] phase_acc, active_tune, a0;
    logic [11:0] phase_out, active_offs;
    int          miscompares, checked;
    localparam logic [27:0] TA = 28'h9a5c3e1;
    localparam logic [27:0] TB = 28'h5e6f0a7;
    localparam logic [27:0] TH = {14'h00ff, 14'h3fff};
    ddstw_if lnk ();
    ddstw_host i_ddstw_host (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .lnk(lnk));
    ddstw_dev i_ddstw_dev (.pclk, .presetn, .lnk(lnk), .phase_acc,
        .phase_out, .out_valid, .active_tune, .active_offs);
    ddstw_assertions i_ddstw_assertions (.pclk, .presetn,
        .sclk(lnk.sclk), .sync_n(lnk.sync_n), .serial_in(lnk.serial_in),
        .out_valid, .phase_acc, .active_tune);
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic print_verdict();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) miscompares++;
        q       = prdata;
        perr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // A write while busy is dropped, so poll before moving on
    task automatic send(input logic [15:0] w);
        int k;
        k = 0;
        apb(1'b1, ddstw_pkg::REG_TX, {16'h0000, w});
        do begin
            apb(1'b0, ddstw_pkg::REG_STATUS, 32'h0);
            k++;
        end while (q[0] !== 1'b0 && k < 100);
        if (k >= 100) miscompares++;
        repeat (6) @(posedge pclk);
    endtask : send
    task automatic pins(input logic [2:0] p);
        apb(1'b1, ddstw_pkg::REG_PINS, {29'h0, p});
    endtask : pins
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        presetn = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        send(16'h2000);
        send({2'b01, TA[13:0]});
        send({2'b01, TA[27:14]});
        `CHK(active_tune, TA)
        a0 = phase_acc;
        @(posedge pclk);
        `CHK(phase_acc - a0, TA)
        send(16'h2800);
        send({2'b10, TB[13:0]});
        send({2'b10, TB[27:14]});
        `CHK(active_tune, TB)
        send(16'h0800);
        send({2'b10, 14'h3fff});
        `CHK(active_tune, {TB[27:14], 14'h3fff})
        send(16'h1800);
        send({2'b10, 14'h00ff});
        `CHK(active_tune, TH)
        send(16'h1000);
        `CHK(active_tune, TA)
        send(16'hc123);
        send(16'hf456);
        `CHK(active_offs, 12'h123)
        send(16'h0400);
        `CHK(active_offs, 12'h456)
        send(16'h0500);
        `CHK(out_valid, 1'b0)
        `CHK(phase_acc, 28'h0000000)
        `CHK(active_offs, 12'h456)
        send(16'h0400);
        repeat (6) @(posedge pclk);
        `CHK(out_valid, 1'b1)
        // Offset word one is active, so the adder must add it
        a0 = phase_acc;
        @(posedge pclk);
        `CHK(phase_out, a0[27:16] + 12'h456)
        pins(3'b100);
        repeat (4) @(posedge pclk);
        `CHK(out_valid, 1'b1)
        send(16'h0200);
        `CHK(out_valid, 1'b0)
        pins(3'b001);
        repeat (4) @(posedge pclk);
        `CHK(out_valid, 1'b0)
        repeat (6) @(posedge pclk);
        `CHK(out_valid, 1'b1)
        `CHK(active_tune, TH)
        `CHK(active_offs, 12'h123)
        pins(3'b101);
        // Registered output needs one edge after the pin rises
        @(posedge pclk);
        `CHK(out_valid, 1'b0)
        `CHK(active_tune, TH)
        apb(1'b0, 8'h0c, 32'h0);
        `CHK(perr, 1'b1)
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        print_verdict();
    end
endmodule : tb_dds_tuning_word_registers
